// *** rtl/bgd_guard.sv ***
// Beam guard test handling, beam safety outputs, heartbeat and diagnostics.
// Assumes pin levels arrive asynchronously; fault_code_in is on clk_sys.
`timescale 1ns/1ps
module bgd_guard #(
	parameter int BEAM_COUNT    = 4,
	parameter int MS_CYCLES     = bgd_pkg::MS_CYCLES,
	parameter int HB_HALF_MS    = bgd_pkg::HB_HALF_MS,
	parameter int TEST_LIMIT_MS = bgd_pkg::TEST_LIMIT_MS,
	parameter int TX_RESTART_MS = bgd_pkg::TX_RESTART_MS,
	parameter int RX_RESTART_MS = bgd_pkg::RX_RESTART_MS
) (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       test_pin_high,
	input  wire logic       supply_a_pos,
	input  wire logic       supply_b_pos,
	input  wire logic [3:0] beam_clear,
	input  wire logic       ambient_interference,
	input  wire logic       output_cross_circuit,
	input  wire logic       output_short_gnd,
	input  wire logic       output_short_vcc,
	input  wire logic       supply_undervoltage,
	input  wire logic       supply_overvoltage,
	input  wire logic       receiver_hw_fault,
	input  wire logic       tx_test_input_problem,
	input  wire logic       tx_hw_fault,
	input  wire logic [7:0] fault_code_in,
	output logic            beam1_safety_output,
	output logic            beam2_safety_output,
	output logic            beam3_safety_output,
	output logic            beam4_safety_output,
	output logic            shared_heartbeat_output,
	output logic            optical_channel_one,
	output logic            optical_channel_two,
	output logic            external_test_active,
	output logic            error_active,
	output logic            code_is_error,
	output logic [7:0]      correctable_error_code,
	output logic            code_is_fault,
	output logic [7:0]      internal_fault_code,
	output logic            display_digit_eight,
	output logic            transmitter_status_lamp
);
	localparam int MW = bgd_pkg::MS_W;
	localparam int CW = bgd_pkg::CNT_W;

	typedef struct packed {
		bgd_pkg::bgd_err_st_t st;
		logic [MW-1:0]        ms_cnt;
		logic                 tick;
		logic [CW-1:0]        hb_ms;
		logic                 hb;
		logic                 ext;
		logic [3:0]           off_mask;
		logic [CW-1:0]        test_ms;
		logic                 test_over;
		logic [CW-1:0]        rst_ms;
		logic                 is_err;
		logic [7:0]           code;
		logic                 is_fault;
		logic [7:0]           fcode;
		logic                 digit8;
		logic [CW-1:0]        tx_ms;
		logic                 tx_hold;
		logic [3:0]           beam;
		logic                 ch1;
		logic                 ch2;
	} bgd_state_t;

	bgd_state_t s_q;
	bgd_state_t s_d;

	bgd_sync_if #(.W(bgd_pkg::SYN_W)) syn_if ();
	logic [bgd_pkg::SYN_W-1:0] syn;

	assign syn_if.raw = {tx_hw_fault, tx_test_input_problem, receiver_hw_fault,
		supply_overvoltage, supply_undervoltage, output_short_vcc, output_short_gnd,
		output_cross_circuit, ambient_interference, beam_clear, supply_b_pos,
		supply_a_pos, test_pin_high};
	assign syn = syn_if.sync;

	bgd_sync #(.W(bgd_pkg::SYN_W)) u_sync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.port    (syn_if.snk)
	);

	logic       cond;
	logic       hw;
	logic [7:0] ecode;
	logic       txc;
	logic       running;

	always_comb
	begin
		s_d = s_q;
		// Free-running millisecond tick
		s_d.tick   = (s_q.ms_cnt == MW'(MS_CYCLES - 1));
		s_d.ms_cnt = s_d.tick ? '0 : s_q.ms_cnt + 1'b1;

		s_d.ext = !syn[bgd_pkg::P_TEST];
		if (!s_d.ext)
		begin
			s_d.off_mask  = '0;
			s_d.test_ms   = '0;
			s_d.test_over = 1'b0;
		end
		else if (!s_q.ext)
			s_d.off_mask = 4'h1;
		else if (s_q.tick)
		begin
			s_d.off_mask = {s_q.off_mask[2:0], 1'b1};
			if (s_q.test_ms != CW'(TEST_LIMIT_MS))
				s_d.test_ms = s_q.test_ms + 1'b1;
			else
				s_d.test_over = 1'b1;
		end

		// Supply faults rank first; a dead supply makes other flags suspect
		hw = syn[bgd_pkg::P_RX_HW];
		if (syn[bgd_pkg::P_UNDERV])
			ecode = bgd_pkg::ERR_UNDERV;
		else if (syn[bgd_pkg::P_OVERV])
			ecode = bgd_pkg::ERR_OVERV;
		else if (syn[bgd_pkg::P_AMBIENT])
			ecode = bgd_pkg::ERR_AMBIENT;
		else if (syn[bgd_pkg::P_CROSS])
			ecode = bgd_pkg::ERR_CROSS;
		else if (syn[bgd_pkg::P_SHORT_GND])
			ecode = bgd_pkg::ERR_SHORT_GND;
		else if (syn[bgd_pkg::P_SHORT_VCC])
			ecode = bgd_pkg::ERR_SHORT_VCC;
		else
			ecode = bgd_pkg::ERR_TEST_TIME;
		cond = hw || s_q.test_over || (|syn[bgd_pkg::P_OVERV:bgd_pkg::P_AMBIENT]);

		case (s_q.st)
			bgd_pkg::ST_RUN:
			begin
				if (cond)
					s_d.st = bgd_pkg::ST_HOLD;
			end
			bgd_pkg::ST_HOLD:
			begin
				// Code held until restart, then rechecked
				if (s_q.tick)
				begin
					if (s_q.rst_ms == CW'(RX_RESTART_MS - 1))
					begin
						s_d.rst_ms = '0;
						if (!cond)
						begin
							s_d.st       = bgd_pkg::ST_RUN;
							s_d.is_err   = 1'b0;
							s_d.is_fault = 1'b0;
							s_d.digit8   = 1'b0;
							s_d.code     = '0;
							s_d.fcode    = '0;
						end
					end
					else
						s_d.rst_ms = s_q.rst_ms + 1'b1;
				end
			end
			default:
				s_d.st = bgd_pkg::ST_RUN;
		endcase

		// Latch on entry and on a restart that still sees the condition
		if (cond && (s_q.st == bgd_pkg::ST_RUN
			|| (s_q.tick && s_q.rst_ms == CW'(RX_RESTART_MS - 1))))
		begin
			s_d.rst_ms   = '0;
			s_d.is_fault = hw;
			s_d.is_err   = !hw;
			s_d.digit8   = hw;
			s_d.fcode    = hw ? fault_code_in : 8'h00;
			s_d.code     = hw ? 8'h00 : ecode;
		end

		// Heartbeat runs only in internal test with no error
		running = (s_d.st == bgd_pkg::ST_RUN) && !s_d.ext;
		if (!running)
		begin
			s_d.hb    = 1'b0;
			s_d.hb_ms = '0;
		end
		else if (s_q.tick)
		begin
			if (s_q.hb_ms == CW'(HB_HALF_MS - 1))
			begin
				s_d.hb    = !s_q.hb;
				s_d.hb_ms = '0;
			end
			else
				s_d.hb_ms = s_q.hb_ms + 1'b1;
		end

		for (int i = 0; i < 4; i++)
			s_d.beam[i] = syn[bgd_pkg::P_BEAM + i]
				&& (i < BEAM_COUNT)
				&& !s_d.off_mask[i]
				&& (s_d.st == bgd_pkg::ST_RUN);

		s_d.ch1 = syn[bgd_pkg::P_SUP_A] && !syn[bgd_pkg::P_SUP_B];
		s_d.ch2 = !syn[bgd_pkg::P_SUP_A] && syn[bgd_pkg::P_SUP_B];

		// Transmitter side: shorter restart, lamp follows its hold
		txc = syn[bgd_pkg::P_TX_TEST] || syn[bgd_pkg::P_TX_HW];
		if (!s_q.tx_hold)
		begin
			s_d.tx_hold = txc;
			s_d.tx_ms   = '0;
		end
		else if (s_q.tick)
		begin
			if (s_q.tx_ms == CW'(TX_RESTART_MS - 1))
			begin
				s_d.tx_hold = txc;
				s_d.tx_ms   = '0;
			end
			else
				s_d.tx_ms = s_q.tx_ms + 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign beam1_safety_output     = s_q.beam[0];
	assign beam2_safety_output     = s_q.beam[1];
	assign beam3_safety_output     = s_q.beam[2];
	assign beam4_safety_output     = s_q.beam[3];
	assign shared_heartbeat_output = s_q.hb;
	assign optical_channel_one     = s_q.ch1;
	assign optical_channel_two     = s_q.ch2;
	assign external_test_active    = s_q.ext;
	assign error_active            = (s_q.st == bgd_pkg::ST_HOLD);
	assign code_is_error           = s_q.is_err;
	assign correctable_error_code  = s_q.code;
	assign code_is_fault           = s_q.is_fault;
	assign internal_fault_code     = s_q.fcode;
	assign display_digit_eight     = s_q.digit8;
	assign transmitter_status_lamp = s_q.tx_hold;

	// Checking helpers: cycles between heartbeat edges
	localparam int HB_PERIOD = HB_HALF_MS * MS_CYCLES;
	logic [31:0] h_cnt;
	logic        h_seen;
	logic        hb_prev;
	logic        h_run;
	assign h_run = (s_q.st == bgd_pkg::ST_RUN) && !s_q.ext;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			h_cnt   <= '0;
			h_seen  <= 1'b0;
			hb_prev <= 1'b0;
		end
		else
		begin
			hb_prev <= s_q.hb;
			h_cnt   <= (s_q.hb != hb_prev) ? 32'h0000_0000 : h_cnt + 1'b1;
			h_seen  <= h_run && (h_seen || s_q.hb != hb_prev);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_hb_period;
		(s_q.hb != hb_prev) && h_seen && h_run |-> h_cnt == 32'(HB_PERIOD - 1);
	endproperty
	a_hb_period: assert property (p_hb_period) else $error("heartbeat phase wrong");

	property p_hb_static;
		(s_q.st == bgd_pkg::ST_HOLD) |-> !s_q.hb ##1 !s_q.hb || s_q.st == bgd_pkg::ST_RUN;
	endproperty
	a_hb_static: assert property (p_hb_static) else $error("heartbeat moves in error");

	property p_beams_off;
		error_active |-> s_q.beam == 4'h0;
	endproperty
	a_beams_off: assert property (p_beams_off) else $error("beam on during error");

	property p_unused_beam;
		(BEAM_COUNT < 4) |-> !beam4_safety_output && (BEAM_COUNT > 2 || !beam3_safety_output);
	endproperty
	a_unused_beam: assert property (p_unused_beam) else $error("unused beam on");

	property p_ext_test;
		!syn[bgd_pkg::P_TEST] |=> external_test_active && !beam1_safety_output
			&& !shared_heartbeat_output;
	endproperty
	a_ext_test: assert property (p_ext_test) else $error("test not honoured");

	property p_chan;
		syn[bgd_pkg::P_SUP_A] && !syn[bgd_pkg::P_SUP_B] |=> optical_channel_one
			&& !optical_channel_two;
	endproperty
	a_chan: assert property (p_chan) else $error("channel select wrong");

	property p_hold_code;
		$rose(error_active) |=> ($stable(correctable_error_code) && error_active)[*8];
	endproperty
	a_hold_code: assert property (p_hold_code) else $error("code not held");

	property p_underv;
		!error_active && syn[bgd_pkg::P_UNDERV] && !syn[bgd_pkg::P_RX_HW]
			|=> code_is_error && correctable_error_code == 8'h14;
	endproperty
	a_underv: assert property (p_underv) else $error("undervoltage code wrong");

	property p_fault_eight;
		code_is_fault |-> display_digit_eight && !code_is_error && error_active;
	endproperty
	a_fault_eight: assert property (p_fault_eight) else $error("fault display wrong");

	property p_tx_lamp;
		!transmitter_status_lamp && syn[bgd_pkg::P_TX_HW] |=> transmitter_status_lamp;
	endproperty
	a_tx_lamp: assert property (p_tx_lamp) else $error("lamp not lit");

	property p_test_over;
		s_q.test_over |-> s_q.ext && s_q.test_ms == CW'(TEST_LIMIT_MS) ##1 error_active;
	endproperty
	a_test_over: assert property (p_test_over) else $error("test time error missed");

endmodule : bgd_guard

// *** rtl/bgd_pkg.sv ***
// Constants and types shared by the beam guard safety-output logic.
// Assumes one 250 MHz system clock; all slow timing runs off a 1 ms tick.
package bgd_pkg;

	// Clock rate and the millisecond tick derived from it
	localparam int CLK_HZ    = 250_000_000;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int MS_W      = 18;

	// Times, in milliseconds
	localparam int HB_HALF_MS     = 300;
	localparam int TEST_LIMIT_MS  = 150;
	localparam int TX_RESTART_MS  = 2000;
	localparam int RX_RESTART_MS  = 20000;
	localparam int CNT_W          = 16;

	// Bit positions in the synchronised pin vector
	localparam int SYN_W      = 16;
	// Idle pin levels loaded in reset; test pin at the supply means no test
	localparam logic [SYN_W-1:0] SYN_IDLE = 16'h0001;
	localparam int P_TEST     = 0;
	localparam int P_SUP_A    = 1;
	localparam int P_SUP_B    = 2;
	localparam int P_BEAM     = 3;
	localparam int P_AMBIENT  = 7;
	localparam int P_CROSS    = 8;
	localparam int P_SHORT_GND = 9;
	localparam int P_SHORT_VCC = 10;
	localparam int P_UNDERV   = 11;
	localparam int P_OVERV    = 12;
	localparam int P_RX_HW    = 13;
	localparam int P_TX_TEST  = 14;
	localparam int P_TX_HW    = 15;

	// Correctable error codes, two BCD digits
	localparam logic [7:0] ERR_AMBIENT   = 8'h00;
	localparam logic [7:0] ERR_CROSS     = 8'h01;
	localparam logic [7:0] ERR_SHORT_GND = 8'h06;
	localparam logic [7:0] ERR_SHORT_VCC = 8'h07;
	localparam logic [7:0] ERR_UNDERV    = 8'h14;
	localparam logic [7:0] ERR_TEST_TIME = 8'h18;
	localparam logic [7:0] ERR_OVERV     = 8'h22;

	typedef enum logic {ST_RUN, ST_HOLD} bgd_err_st_t;

endpackage : bgd_pkg

// *** rtl/bgd_sync_if.sv ***
// Bundle between the pin synchroniser and the safety-output core.
// Assumes both ends sit on clk_sys.
`timescale 1ns/1ps
interface bgd_sync_if #(parameter int W = 16);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport src (output raw, input sync);
	modport snk (input raw, output sync);
endinterface : bgd_sync_if

// *** rtl/bgd_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes the levels are quasi-static; no bus coherency across bits.
`timescale 1ns/1ps
module bgd_sync #(
	parameter int W = 16
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	bgd_sync_if.snk   port
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} bgd_sync_st_t;

	bgd_sync_st_t s_q;
	bgd_sync_st_t s_d;

	// First stage feeds only the second stage
	always_comb
	begin
		s_d.meta = port.raw;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk_sys)
	begin
		// Reset to idle levels, else a false external test follows release
		if (sys_rst)
		begin
			s_q.meta <= W'(bgd_pkg::SYN_IDLE);
			s_q.sync <= W'(bgd_pkg::SYN_IDLE);
		end
		else
			s_q <= s_d;
	end

	assign port.sync = s_q.sync;

endmodule : bgd_sync

// *** bench/bgd_ctrl_model.sv ***
// Downstream safety control model: drives the test pin, watches the outputs.
// Assumes it shares clk_sys and sys_rst with the guard.
`timescale 1ns/1ps
module bgd_ctrl_model #(
	parameter int STATIC_LIMIT = 70
) (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       test_req,
	input  wire logic       heartbeat,
	input  wire logic [3:0] beams,
	input  wire logic       error_seen,
	output logic            test_pin_high,
	output logic            machine_stop
);
	logic [15:0] static_q;
	logic        hb_q;

	// Test output pulls the pin to 0 V; released it sits at the supply
	assign test_pin_high = ~test_req;

	always_ff @(posedge clk_sys)
	begin
		hb_q <= heartbeat;
		if (sys_rst || heartbeat != hb_q)
			static_q <= 16'h0000;
		else if (static_q != 16'hffff)
			static_q <= static_q + 16'h0001;
	end

	// Static heartbeat, any beam off or a signalled error stops the machine
	// Under external test the heartbeat is skipped; beam outputs and error are still evaluated
	assign machine_stop = ((static_q > 16'(STATIC_LIMIT)) && !test_req)
		|| (beams != 4'hf) || error_seen;
endmodule : bgd_ctrl_model

// *** bench/tb.sv ***
// Self-checking bench for the beam guard with shortened millisecond timing.
// Assumes the controller model in bgd_ctrl_model.sv; inputs change at negedge.
`timescale 1ns/1ps
module tb;
	localparam int MS  = 10;
	localparam int HB  = 3;
	localparam int TL  = 5;
	localparam int TXR = 4;
	localparam int RXR = 8;
	localparam int RXW = RXR * MS;
	localparam logic [7:0] CODES [6] = '{8'h00, 8'h01, 8'h06, 8'h07, 8'h14, 8'h22};

	logic       clk_sys, sys_rst, test_req, test_pin_high, stop, sup_a, sup_b;
	logic       rx_hw, tx_prob, tx_hw, b1, b2, b3, b4, t3, t4, hb, ch1, ch2, ext;
	logic       err, is_err, is_flt, dig8, lamp;
	logic [3:0] beam_clear;
	logic [5:0] det;
	logic [7:0] fcode, ecode, fcode_out;
	int         fail_count, num_checks, n;

	bgd_guard #(.BEAM_COUNT(4), .MS_CYCLES(MS), .HB_HALF_MS(HB), .TEST_LIMIT_MS(TL),
		.TX_RESTART_MS(TXR), .RX_RESTART_MS(RXR)) i_bgd_guard (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .test_pin_high(test_pin_high),
		.supply_a_pos(sup_a), .supply_b_pos(sup_b), .beam_clear(beam_clear),
		.ambient_interference(det[0]), .output_cross_circuit(det[1]),
		.output_short_gnd(det[2]), .output_short_vcc(det[3]),
		.supply_undervoltage(det[4]), .supply_overvoltage(det[5]),
		.receiver_hw_fault(rx_hw), .tx_test_input_problem(tx_prob), .tx_hw_fault(tx_hw),
		.fault_code_in(fcode), .beam1_safety_output(b1), .beam2_safety_output(b2),
		.beam3_safety_output(b3), .beam4_safety_output(b4), .shared_heartbeat_output(hb),
		.optical_channel_one(ch1), .optical_channel_two(ch2), .external_test_active(ext),
		.error_active(err), .code_is_error(is_err), .correctable_error_code(ecode),
		.code_is_fault(is_flt), .internal_fault_code(fcode_out),
		.display_digit_eight(dig8), .transmitter_status_lamp(lamp));

	// Two-beam unit on the same pins; only its upper outputs are watched
	bgd_guard #(.BEAM_COUNT(2), .MS_CYCLES(MS), .HB_HALF_MS(HB), .TEST_LIMIT_MS(TL),
		.TX_RESTART_MS(TXR), .RX_RESTART_MS(RXR)) i_bgd_guard_b2 (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .test_pin_high(test_pin_high),
		.supply_a_pos(sup_a), .supply_b_pos(sup_b), .beam_clear(beam_clear),
		.ambient_interference(det[0]), .output_cross_circuit(det[1]),
		.output_short_gnd(det[2]), .output_short_vcc(det[3]),
		.supply_undervoltage(det[4]), .supply_overvoltage(det[5]),
		.receiver_hw_fault(rx_hw), .tx_test_input_problem(tx_prob), .tx_hw_fault(tx_hw),
		.fault_code_in(fcode), .beam1_safety_output(), .beam2_safety_output(),
		.beam3_safety_output(t3), .beam4_safety_output(t4), .shared_heartbeat_output(),
		.optical_channel_one(), .optical_channel_two(), .external_test_active(),
		.error_active(), .code_is_error(), .correctable_error_code(),
		.code_is_fault(), .internal_fault_code(), .display_digit_eight(),
		.transmitter_status_lamp());

	bgd_ctrl_model #(.STATIC_LIMIT(2 * HB * MS + 10)) i_bgd_ctrl_model (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .test_req(test_req), .heartbeat(hb),
		.beams({b4, b3, b2, b1}), .error_seen(err), .test_pin_high(test_pin_high),
		.machine_stop(stop));

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask : cyc

	function automatic logic pick(input int sel);
		case (sel)
			0: return err;
			1: return lamp;
			default: return hb;
		endcase
	endfunction : pick

	// Bounded wait for a level; running out ends the run
	task automatic wait_lvl(input int sel, input logic lvl, input int lim);
		int k;
		for (k = 0; k < lim && pick(sel) !== lvl; k++)
			@(negedge clk_sys);
		if (k == lim)
		begin
			fail_count++;
			$display("ERROR t=%0t wait %0h timed out got=%h exp=%h", $time, sel, pick(sel), lvl);
			end_of_test;
		end
	endtask : wait_lvl

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial
	begin
		cyc(20000);
		fail_count++;
		end_of_test;
	end

	initial
	begin
		fail_count = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		test_req = 1'b0;
		{sup_a, sup_b} = 2'b10;
		beam_clear = 4'hf;
		det = 6'h00;
		{rx_hw, tx_prob, tx_hw} = 3'b000;
		fcode = 8'h5a;
		cyc(6);
		chk(8'({b1, b2, b3, b4, hb, err, lamp}), 8'h00);
		sys_rst = 1'b0;
		cyc(4);
		chk(8'({ch1, ch2}), 8'h02);
		{sup_a, sup_b} = 2'b01;
		cyc(4);
		chk(8'({ch1, ch2}), 8'h01);
		// Equal supply levels select no channel
		{sup_a, sup_b} = 2'b11;
		cyc(4);
		chk(8'({ch1, ch2}), 8'h00);
		{sup_a, sup_b} = 2'b01;
		beam_clear = 4'ha;
		cyc(4);
		chk(8'({b4, b3, b2, b1}), 8'h0a);
		chk(8'({t4, t3}), 8'h00);
		beam_clear = 4'hf;
		cyc(4);
		chk(8'({t4, t3, stop}), 8'h00);
		// Both phases of the heartbeat, counted in whole cycles
		wait_lvl(2, 1'b0, 200);
		wait_lvl(2, 1'b1, 200);
		for (int lv = 1; lv >= 0; lv--)
		begin
			for (n = 0; hb === 1'(lv) && n < 100; n++)
				cyc(1);
			chk(8'(n), 8'(HB * MS));
		end
		test_req = 1'b1;
		cyc(4);
		chk(8'({ext, b1, b4}), 8'h05);
		cyc(36);
		chk(8'({b4, b3, b2, b1, hb}), 8'h00);
		test_req = 1'b0;
		cyc(4);
		chk(8'({err, b4, b3, b2, b1}), 8'h0f);
		// Test held past its time limit
		test_req = 1'b1;
		wait_lvl(0, 1'b1, 150);
		chk(ecode, 8'h18);
		chk(8'({is_err, b1, b2, b3, b4}), 8'h10);
		det = 6'h01;
		cyc(20);
		chk(ecode, 8'h18);
		det = 6'h00;
		test_req = 1'b0;
		cyc(40);
		chk(8'({err, hb, stop}), 8'h05);
		wait_lvl(0, 1'b0, 3 * RXW);
		cyc(4);
		chk(8'({b4, b3, b2, b1}), 8'h0f);
		for (int i = 0; i < 6; i++)
		begin
			det = 6'h01 << i;
			wait_lvl(0, 1'b1, 20);
			chk(ecode, CODES[i]);
			chk(8'({is_err, is_flt, b1}), 8'h04);
			det = 6'h00;
			wait_lvl(0, 1'b0, 3 * RXW);
		end
		// Condition still present at restart keeps the error
		det = 6'h10;
		wait_lvl(0, 1'b1, 20);
		cyc(RXW + 30);
		chk(8'({err, ecode[4:0]}), 8'h34);
		det = 6'h00;
		wait_lvl(0, 1'b0, 3 * RXW);
		rx_hw = 1'b1;
		wait_lvl(0, 1'b1, 20);
		chk(8'({is_flt, dig8}), 8'h03);
		chk(fcode_out, 8'h5a);
		// Fault code is captured at entry, not followed while held
		fcode = 8'hc3;
		cyc(2);
		chk(fcode_out, 8'h5a);
		rx_hw = 1'b0;
		wait_lvl(0, 1'b0, 3 * RXW);
		for (int i = 0; i < 2; i++)
		begin
			{tx_hw, tx_prob} = 2'(i + 1);
			cyc(4);
			chk(8'(lamp), 8'h01);
			{tx_hw, tx_prob} = 2'b00;
			cyc(20);
			chk(8'(lamp), 8'h01);
			wait_lvl(1, 1'b0, 100);
		end
		end_of_test;
	end
endmodule : tb
